// >>> inc/pmrc_map.svh
// Purpose: Offsets, field positions, reset values and counts for the power/reset block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef PMRC_MAP_SVH
`define PMRC_MAP_SVH
// ==========================================================
// Register offsets
`define OFF_AUX        8'h00
`define OFF_AUX1       8'h04
`define OFF_MODE       8'h08
`define OFF_STAT       8'h0c
// ==========================================================
// Field positions
`define BIT_ALE_QUIET  0
`define BIT_LOW_POWER  4
`define BIT_WAKE_EN    3
`define BIT_IDLE_REQ   0
`define BIT_PD_REQ     1
// ==========================================================
// Reset values and counts
`define AUX_RST        8'h00
`define AUX1_RST       8'h00
`define LAST_STATE     3'd5
`define RST_HIGH_CNT   5'd24
`define ONCHIP_TOP     16'h0fff
`endif

// >>> inc/pmrc_pkg.sv
// Purpose: Types shared by the power/reset block
// Assumes: Nothing
// Notes:   Constants live in pmrc_map.svh
package pmrc_pkg;
  // ==========================================================
  // Power modes
  typedef enum logic [1:0]
  {
    st_run   = 2'b00,
    st_idle  = 2'b01,
    st_pdown = 2'b10,
    st_wake  = 2'b11
  } pmode_t;
endpackage

// >>> inc/strobe_if.sv
// Purpose: Carrier between the mode control and the strobe timing generator
// Assumes: One clock, pclk
// Notes:   gen drives timing, ctl consumes it
`timescale 1ns/1ps
interface strobe_if;
  logic       osc_run;   // Oscillator running
  logic       movx;      // External data access in this machine cycle
  logic       ext_fetch; // Code fetched from external memory
  logic       ale_quiet; // Address strobe only during data access
  logic       phase;     // Divide-by-two state
  logic [2:0] state;     // State within machine cycle
  logic       mc_end;    // Last oscillator period of a machine cycle
  logic       ale;       // Address latch strobe, high active
  logic       program_fetch_strobe_n;    // Program fetch strobe, low active
  modport gen (input osc_run, movx, ext_fetch, ale_quiet,
               output phase, state, mc_end, ale, program_fetch_strobe_n);
  modport ctl (output osc_run, movx, ext_fetch, ale_quiet,
               input phase, state, mc_end, ale, program_fetch_strobe_n);
endinterface

// >>> core/strobe_gen.sv
// Purpose: Divide-by-two clock, machine cycle states, address and fetch strobes
// Assumes: pclk is the oscillator input
// Notes:   Counters freeze while the oscillator is stopped
`timescale 1ns/1ps
`include "pmrc_map.svh"
module strobe_gen
(
  input  wire logic pclk,    // Oscillator clock
  input  wire logic presetn, // Async reset, low active
  strobe_if.gen     sif      // Timing carrier
);
  // ==========================================================
  // Divider: one state is two oscillator periods
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sif.phase <= 1'b0;
      sif.state <= 3'd0;
    end
    else if (sif.osc_run)
    begin
      sif.phase <= ~sif.phase;
      if (sif.phase)
        sif.state <= (sif.state == `LAST_STATE) ? 3'd0 : 3'(sif.state + 3'd1);
    end
  end

  assign sif.mc_end = sif.osc_run && sif.phase && (sif.state == `LAST_STATE);

  // ==========================================================
  // Strobes: address strobe in states 0 and 3, fetch strobe in states 1 and 4
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sif.ale    <= 1'b0;
      sif.program_fetch_strobe_n <= 1'b1;
    end
    else
    begin
      // Skip the first address strobe of a data access; quiet mode keeps only that access's
      sif.ale <= sif.osc_run && (((sif.state == 3'd0) && !sif.movx && !sif.ale_quiet)
                 || (sif.state == 3'd3 && (!sif.ale_quiet || sif.movx)));
      // Both fetch pulses are dropped in a data access cycle
      sif.program_fetch_strobe_n <= !(sif.osc_run && sif.ext_fetch && !sif.movx
                    && (sif.state == 3'd1 || sif.state == 3'd4));
    end
  end

  // ==========================================================
  // Checks
  sequence s_fetch_slot;
    sif.osc_run && sif.ext_fetch && !sif.movx && sif.state == 3'd1 && !sif.phase;
  endsequence
  // Fetch source must hold over the slot, else the second half is legally dropped
  sequence s_fetch_hold;
    sif.osc_run && sif.ext_fetch && !sif.movx;
  endsequence
  a_program_fetch_strobe_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_fetch_slot ##1 s_fetch_hold |-> !sif.program_fetch_strobe_n ##1 !sif.program_fetch_strobe_n)
    else $error("fetch strobe missing");
  a_divide_two: assert property (@(posedge pclk) disable iff (!presetn)
    sif.osc_run |=> sif.phase != $past(sif.phase)) else $error("divider stuck");
endmodule

// >>> core/rst_qualify.sv
// Purpose: Reset pin synchroniser and pulse length qualifier
// Assumes: Pin is asynchronous to pclk
// Notes:   Short pulses are ignored
`timescale 1ns/1ps
`include "pmrc_map.svh"
module rst_qualify
(
  input  wire logic pclk,     // Oscillator clock
  input  wire logic presetn,  // Async reset, low active
  input  wire logic osc_run,  // Oscillator running
  input  wire logic rst_pin,  // Reset pin, high active
  output logic      rst_seen, // Synchronised pin level
  output logic      core_rst  // Qualified internal reset
);
  logic       meta_q;
  logic [4:0] hi_cnt_q;

  // ==========================================================
  // Two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= 1'b0;
      rst_seen <= 1'b0;
    end
    else
    begin
      meta_q   <= rst_pin;
      rst_seen <= meta_q;
    end
  end

  // ==========================================================
  // Count consecutive high samples while the oscillator runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_cnt_q <= 5'd0;
    else if (!rst_seen)
      hi_cnt_q <= 5'd0;
    else if (osc_run && hi_cnt_q != `RST_HIGH_CNT)
      hi_cnt_q <= 5'(hi_cnt_q + 5'd1);
  end

  assign core_rst = (hi_cnt_q == `RST_HIGH_CNT);

  a_rst_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_rst) |-> $past(rst_seen, 1) && $past(hi_cnt_q) == 5'd23)
    else $error("reset qualified too early");
endmodule

// >>> core/power_mode_reset_control.sv
// Purpose: Reset, clocking, idle, power-down, wake and emulation entry control
// Assumes: pclk is the oscillator at 25 MHz; inputs synchronous except reset pin
// Notes:   Registers over APB, zero wait states
// Operation
// - External fetch: two fetch strobes per machine cycle, both dropped in data access.
// - No fetch strobe while fetching from internal program memory.
// - Fetch select high: internal memory until program counter passes on-chip top.
// - With security bit 1, fetch select is latched at reset and used afterwards.
// - Internal timing comes from a divide-by-two of the oscillator.
// - Reset needs pin high for 24 oscillator periods while running.
// - Static: stopped clock keeps RAM and register contents.
// - Idle stops the processor after the instruction; peripherals stay clocked.
// - Idle ends on enabled interrupt or on hardware reset.
// - Power-down stops the oscillator after the entering instruction.
// - Power-down ends on reset (registers reinitialised) or external interrupt.
// - Interrupt wake from power-down only with the wake enable bit set.
// - Enabled low level interrupt restarts oscillator; pin high completes the exit.
// - After wake service, execution resumes after the power-down instruction.
// - Low power bit shuts down program memory analog circuits.
// - Reset ending idle: block RAM access, not ports, until internal reset.
// - Emulation: port 0 floats, strobes and ports weakly pulled, oscillator runs.
// - Idle strobes read 1, power-down 0; port 0 floats on external program.
// - Address strobe at one sixth oscillator rate, one skipped per data access.
`timescale 1ns/1ps
`include "pmrc_map.svh"
module power_mode_reset_control
(
  input  wire logic        pclk,                  // Oscillator clock
  input  wire logic        presetn,               // Async reset, low active
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB write
  input  wire logic [7:0]  paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic      [31:0] prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error, unmapped
  input  wire logic        rst_pin,               // Reset pin, high active
  input  wire logic        external_fetch_select, // High: internal memory first
  input  wire logic        security_bit_one,      // Security bit 1 programmed
  input  wire logic [15:0] prog_counter,          // Processor program counter
  input  wire logic        movx_cycle,            // Data access this machine cycle
  input  wire logic        irq_pending,           // Any enabled interrupt
  input  wire logic        ext_irq_zero_n,        // External interrupt 0 pin
  input  wire logic        ext_irq_one_n,         // External interrupt 1 pin
  input  wire logic        irq_zero_level_en,     // Int 0 enabled, level mode
  input  wire logic        irq_one_level_en,      // Int 1 enabled, level mode
  input  wire logic        ale_in,                // Address strobe pin level
  output logic             ale_out,               // Address strobe drive
  output logic             ale_oe_n,              // Address strobe enable, low drives
  input  wire logic        program_fetch_strobe_in,               // Fetch strobe pin level
  output logic             program_fetch_strobe,  // Fetch strobe drive
  output logic             program_fetch_strobe_oe_n,             // Fetch strobe enable, low drives
  output logic             osc_enable,            // Oscillator amplifier on
  output logic             cpu_run,               // Processor clock enable
  output logic             periph_run,            // Peripheral clock enable
  output logic             sfr_reset,             // Register file reset
  output logic             ram_block,             // Inhibit internal RAM access
  output logic             resume_pulse,          // Vector to interrupt, one cycle
  output logic             port0_float,           // Port 0 released
  output logic             port2_address,         // Port 2 drives address
  output logic             port_weak_pull,        // Ports only weakly pulled
  output logic             eprom_analog_off,      // Program memory analog off
  output logic             fetch_external         // Fetch from external memory
);
  // ==========================================================
  // Declarations
  pmrc_pkg::pmode_t mode_q;
  logic [7:0]       aux_control_q;
  logic [7:0]       aux_control_one_q;
  logic             idle_req_q;
  logic             pd_req_q;
  logic             fetch_sel_q;
  logic             emu_arm_q;
  logic             emu_q;
  logic             core_rst_q;
  logic             rst_seen;
  logic             core_rst;
  logic             ext_eff;
  logic             wake_low;
  logic             wr_en;
  logic             rd_setup;
  logic             mapped;
  logic [31:0]      rd_val;
  strobe_if         sif ();

  // ==========================================================
  // Timing and reset qualifier
  strobe_gen u_strobe
  (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  rst_qualify u_rstq
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .osc_run  (sif.osc_run),
    .rst_pin  (rst_pin),
    .rst_seen (rst_seen),
    .core_rst (core_rst)
  );

  // ==========================================================
  // Fetch source
  // Latched value tracks the pin while reset is held, freezes at release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fetch_sel_q <= 1'b1;
    else if (core_rst)
      fetch_sel_q <= external_fetch_select;
  end

  assign ext_eff        = security_bit_one ? fetch_sel_q : external_fetch_select;
  assign fetch_external = !ext_eff || (prog_counter > `ONCHIP_TOP);

  assign sif.movx      = movx_cycle;
  assign sif.ext_fetch = fetch_external && (mode_q == pmrc_pkg::st_run) && !core_rst;
  assign sif.ale_quiet = aux_control_q[`BIT_ALE_QUIET];

  // ==========================================================
  // APB slave: zero wait, read data captured in setup
  assign wr_en    = psel && penable && pwrite && mapped && !core_rst;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped   = (paddr == `OFF_AUX) || (paddr == `OFF_AUX1)
                 || (paddr == `OFF_MODE) || (paddr == `OFF_STAT);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `OFF_AUX:  rd_val[7:0] = aux_control_q;
      `OFF_AUX1: rd_val[7:0] = aux_control_one_q;
      `OFF_MODE: rd_val[1:0] = {pd_req_q, idle_req_q};
      `OFF_STAT: rd_val[5:0] = {core_rst, emu_q, ext_eff, fetch_external, mode_q};
      default:   rd_val      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_val;
  end

  // ==========================================================
  // Control registers: held while stopped, cleared by internal reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_control_q     <= `AUX_RST;
      aux_control_one_q <= `AUX1_RST;
    end
    else if (core_rst)
    begin
      aux_control_q     <= `AUX_RST;
      aux_control_one_q <= `AUX1_RST;
    end
    else if (wr_en && paddr == `OFF_AUX)
      aux_control_q <= pwdata[7:0];
    else if (wr_en && paddr == `OFF_AUX1)
      aux_control_one_q <= pwdata[7:0];
  end

  assign eprom_analog_off = aux_control_q[`BIT_LOW_POWER];

  // ==========================================================
  // Mode requests: a write on the cycle-end edge wins over the clear, so none is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_req_q <= 1'b0;
      pd_req_q   <= 1'b0;
    end
    else if (wr_en && paddr == `OFF_MODE && mode_q == pmrc_pkg::st_run)
    begin
      idle_req_q <= pwdata[`BIT_IDLE_REQ];
      pd_req_q   <= pwdata[`BIT_PD_REQ];
    end
    else if (core_rst || sif.mc_end)
    begin
      idle_req_q <= 1'b0;
      pd_req_q   <= 1'b0;
    end
  end

  // ==========================================================
  // Power mode state machine
  assign wake_low = aux_control_one_q[`BIT_WAKE_EN]
                 && ((irq_zero_level_en && !ext_irq_zero_n)
                 || (irq_one_level_en && !ext_irq_one_n));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= pmrc_pkg::st_run;
    else if (core_rst)
      mode_q <= pmrc_pkg::st_run;
    else
    begin
      unique case (mode_q)
        pmrc_pkg::st_run:
          if (sif.mc_end && pd_req_q)
            mode_q <= pmrc_pkg::st_pdown;
          else if (sif.mc_end && idle_req_q)
            mode_q <= pmrc_pkg::st_idle;
        pmrc_pkg::st_idle:
          if (irq_pending || rst_seen)
            mode_q <= pmrc_pkg::st_run;
        pmrc_pkg::st_pdown:
          if (wake_low)
            mode_q <= pmrc_pkg::st_wake;
        pmrc_pkg::st_wake:
          if (!wake_low)
            mode_q <= pmrc_pkg::st_run;
      endcase
    end
  end

  // Vector to the interrupt routine; return resumes after the mode instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resume_pulse <= 1'b0;
    else
      resume_pulse <= !core_rst && (((mode_q == pmrc_pkg::st_idle) && irq_pending && !rst_seen)
                   || ((mode_q == pmrc_pkg::st_wake) && !wake_low));
  end

  // ==========================================================
  // Clock enables: a held pin also restarts a stopped oscillator
  assign sif.osc_run = (mode_q != pmrc_pkg::st_pdown) || rst_seen || emu_q;
  assign osc_enable  = sif.osc_run;
  assign cpu_run     = (mode_q == pmrc_pkg::st_run) && !core_rst;
  assign periph_run  = (mode_q == pmrc_pkg::st_run || mode_q == pmrc_pkg::st_idle)
                    && !core_rst;
  assign sfr_reset   = core_rst;

  // RAM access blocked from a reset seen in idle until two cycles after internal reset begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ram_block <= 1'b0;
    else if ((mode_q == pmrc_pkg::st_idle) && rst_seen)
      ram_block <= 1'b1;
    else if (!rst_seen || core_rst_q)
      ram_block <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_rst_q <= 1'b0;
    else
      core_rst_q <= core_rst;
  end

  // ==========================================================
  // Emulation entry: sampled in reset, taken at reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      emu_arm_q <= 1'b0;
      emu_q     <= 1'b0;
    end
    else
    begin
      emu_arm_q <= core_rst && !ale_in && program_fetch_strobe_in;
      if (core_rst_q && !core_rst)
        emu_q <= emu_arm_q && !ale_in;
    end
  end

  // ==========================================================
  // Pin states
  always_comb
  begin
    ale_out              = sif.ale;
    program_fetch_strobe = sif.program_fetch_strobe_n;
    unique case (mode_q)
      pmrc_pkg::st_idle:
      begin
        ale_out              = 1'b1;
        program_fetch_strobe = 1'b1;
      end
      pmrc_pkg::st_pdown, pmrc_pkg::st_wake:
      begin
        ale_out              = 1'b0;
        program_fetch_strobe = 1'b0;
      end
      default:
      begin
        ale_out              = sif.ale;
        program_fetch_strobe = sif.program_fetch_strobe_n;
      end
    endcase
    if (core_rst)
      program_fetch_strobe = 1'b1;
  end

  // Address strobe released in reset so an emulator can pull it low
  assign ale_oe_n       = emu_q || core_rst;
  assign program_fetch_strobe_oe_n      = emu_q;
  assign port_weak_pull = emu_q;
  assign port0_float    = emu_q || (fetch_external && !core_rst);
  assign port2_address  = fetch_external && (mode_q != pmrc_pkg::st_pdown)
                       && (mode_q != pmrc_pkg::st_wake) && !emu_q;

  // ==========================================================
  // Checks
  sequence s_pd_wake_start;
    mode_q == pmrc_pkg::st_pdown && wake_low && !rst_seen;
  endsequence
  sequence s_pin_back;
    mode_q == pmrc_pkg::st_wake && !wake_low && !core_rst;
  endsequence

  a_program_fetch_strobe_internal: assert property (@(posedge pclk) disable iff (!presetn)
    (!fetch_external && mode_q == pmrc_pkg::st_run && !core_rst)[*2]
    |-> program_fetch_strobe) else $error("fetch strobe on internal code");
  a_idle_pins: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == pmrc_pkg::st_idle && !core_rst |-> ale_out && program_fetch_strobe)
    else $error("idle strobes not high");
  a_pd_pins: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == pmrc_pkg::st_pdown && !core_rst |-> !ale_out && !program_fetch_strobe)
    else $error("power-down strobes not low");
  a_pd_osc_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mode_q == pmrc_pkg::st_pdown) && !rst_seen && !emu_q |-> !osc_enable)
    else $error("oscillator runs in power-down");
  a_wake_gated: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == pmrc_pkg::st_pdown && !aux_control_one_q[`BIT_WAKE_EN] && !rst_seen
    |=> mode_q == pmrc_pkg::st_pdown) else $error("wake without enable");
  a_wake_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_pd_wake_start |=> mode_q == pmrc_pkg::st_wake && osc_enable) else $error("no wake start");
  a_wake_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_pin_back |=> mode_q == pmrc_pkg::st_run && resume_pulse)
    else $error("wake exit incomplete");
  a_idle_ram: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == pmrc_pkg::st_idle && rst_seen |=> ram_block && cpu_run)
    else $error("RAM not blocked on idle reset");
  a_emu_pins: assert property (@(posedge pclk) disable iff (!presetn)
    emu_q |-> port0_float && ale_oe_n && program_fetch_strobe_oe_n && osc_enable)
    else $error("emulation pins wrong");
  a_fetch_latch: assert property (@(posedge pclk) disable iff (!presetn)
    security_bit_one && $past(security_bit_one) && !core_rst && !$past(core_rst)
    |-> $stable(ext_eff))
    else $error("latched fetch select moved");
endmodule

// >>> testbench/far_side.sv
// Purpose: Far side of the strobe pins: pull-ups and an emulator
// Assumes: Released strobe pins float high
// Notes:   Emulator pulls the address strobe low only on command
`timescale 1ns/1ps
module far_side
(
  input  wire logic ale_out,              // Address strobe drive
  input  wire logic ale_oe_n,             // Low: device drives it
  input  wire logic program_fetch_strobe, // Fetch strobe drive
  input  wire logic program_fetch_strobe_oe_n,            // Low: device drives it
  input  wire logic emu_hold,             // Emulator wants entry
  output logic      ale_in,               // Resolved address pin
  output logic      program_fetch_strobe_in               // Resolved fetch pin
);
  // ==========================================================
  // Pins resolve to the pull-up level when released
  assign program_fetch_strobe_in = program_fetch_strobe_oe_n ? 1'b1 : program_fetch_strobe;
  // Pulling low only while fetch reads high avoids a false entry
  assign ale_in = (emu_hold && program_fetch_strobe_in) ? 1'b0 : (ale_oe_n ? 1'b1 : ale_out);
endmodule

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for power_mode_reset_control
// Assumes: Zero wait APB, 25 MHz pclk
// Notes:   Seeded LFSR picks program counter values
`timescale 1ns/1ps
`include "pmrc_map.svh"
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h3136;
  logic        pready, pslverr, rst_pin = 0, external_fetch_select = 0;
  logic        security_bit_one = 0, movx_cycle = 0, irq_pending = 0;
  logic        ext_irq_zero_n = 1, ext_irq_one_n = 1, irq_zero_level_en = 1;
  logic        irq_one_level_en = 0, ale_in, ale_out, ale_oe_n, program_fetch_strobe_in, er;
  logic        program_fetch_strobe, program_fetch_strobe_oe_n, osc_enable, cpu_run, periph_run;
  logic        sfr_reset, ram_block, resume_pulse, port0_float, port2_address;
  logic        port_weak_pull, eprom_analog_off, fetch_external, emu_hold = 0;
  logic [15:0] prog_counter = 16'h0000;
  int          n_fail = 0, tests_run = 0, na, np, k;
  power_mode_reset_control power_mode_reset_control_i (.*);
  far_side far_side_i (.*);
  initial forever #20 pclk = ~pclk;
  // ==========================================================
  // Compare, bus and counting helpers
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Counts strobe pulses over ten machine cycles
  task cnt;
    logic pa, pp;
    na = 0;
    np = 0;
    pa = ale_out;
    pp = program_fetch_strobe;
    repeat (120)
    begin
      @(posedge pclk);
      if (ale_out && !pa) na++;
      if (!program_fetch_strobe && pp) np++;
      pa = ale_out;
      pp = program_fetch_strobe;
    end
  endtask
  function logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic fx(input logic [15:0] pc, input logic sel);
    return !sel || (pc > `ONCHIP_TOP);
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    wt(20000);
    n_fail++;
    summarize;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    wt(5);
    presetn <= 1'b1;
    apb(0, `OFF_AUX, 0);
    chk("aux reset", `AUX_RST, rd);
    chk("ready", 1, pready);
    apb(0, 8'h10, 0);
    chk("unmapped error", 1, er);
    apb(1, `OFF_AUX, 32'h10);
    apb(0, `OFF_AUX, 0);
    chk("aux readback", 32'h10, rd);
    chk("analog off", 1, eprom_analog_off);
    apb(1, `OFF_AUX, 0);
    $display("test registers done");
    repeat (40)
    begin
      lf = nxt(lf);
      prog_counter <= lf[15:0];
      external_fetch_select <= lf[16];
      @(posedge pclk);
      chk("fetch external", fx(lf[15:0], lf[16]), fetch_external);
    end
    external_fetch_select <= 1'b0;
    prog_counter <= 16'h0000;
    // Last pass: address strobe quiet mode with no data access
    for (k = 0; k < 4; k++)
    begin
      movx_cycle <= (k == 1);
      external_fetch_select <= (k == 2);
      if (k == 3) apb(1, `OFF_AUX, 32'h1);
      wt(24);
      cnt;
      chk("ale pulses", (k == 1) ? 10 : (k == 3) ? 0 : 20, na);
      chk("fetch pulses", (k == 0 || k == 3) ? 20 : 0, np);
    end
    apb(1, `OFF_AUX, 0);
    $display("test strobes done");
    apb(1, `OFF_MODE, 1);
    for (k = 0; k < 40 && cpu_run !== 1'b0; k++) @(posedge pclk);
    chk("idle cpu", 0, cpu_run);
    chk("idle periph", 1, periph_run);
    chk("idle strobes", 3'b111, {ale_out, program_fetch_strobe, port2_address});
    irq_pending <= 1'b1;
    for (k = 0; k < 10 && resume_pulse !== 1'b1; k++) @(posedge pclk);
    chk("idle resume", 1, resume_pulse);
    irq_pending <= 1'b0;
    $display("test idle done");
    for (int w = 0; w < 2; w++)
    begin
      apb(1, `OFF_AUX1, w << `BIT_WAKE_EN);
      apb(1, `OFF_MODE, 2);
      for (k = 0; k < 40 && osc_enable !== 1'b0; k++) @(posedge pclk);
      chk("pdown osc", 0, osc_enable);
      chk("pdown strobes", 0, {ale_out, program_fetch_strobe, port2_address});
      ext_irq_zero_n <= 1'b0;
      wt(20);
      chk("wake osc", w, osc_enable);
      ext_irq_zero_n <= 1'b1;
      for (k = 0; k < 20 && resume_pulse !== 1'b1; k++) @(posedge pclk);
      chk("wake resume", w, resume_pulse);
      rst_pin <= !w;
      wt(30);
      rst_pin <= 1'b0;
      wt(4);
      chk("pdown exit osc", 1, osc_enable);
    end
    $display("test power down done");
    rst_pin <= 1'b1;
    wt(20);
    rst_pin <= 1'b0;
    wt(8);
    chk("short reset", 0, sfr_reset);
    apb(1, `OFF_MODE, 1);
    wt(30);
    rst_pin <= 1'b1;
    wt(4);
    chk("idle reset ram", 1, ram_block);
    emu_hold <= 1'b1;
    wt(26);
    chk("long reset", 1, sfr_reset);
    rst_pin <= 1'b0;
    wt(8);
    emu_hold <= 1'b0;
    wt(2);
    chk("emulation pins", 5'h1f, {port_weak_pull, port0_float, program_fetch_strobe_oe_n, osc_enable,
        ale_oe_n});
    rst_pin <= 1'b1;
    wt(30);
    rst_pin <= 1'b0;
    wt(6);
    chk("emulation exit", 0, port_weak_pull);
    // Latched select is low from the last reset; the live pin now says internal
    security_bit_one <= 1'b1;
    external_fetch_select <= 1'b1;
    wt(2);
    chk("latched select", 1, fetch_external);
    $display("test reset done");
    summarize;
  end
endmodule
